// File: logic/mfrd_defs.vh
`ifndef MFRD_DEFS_VH
`define MFRD_DEFS_VH

// ----------------------------------------------------------------
// Offsets inside one framer space
// ----------------------------------------------------------------
`define MFRD_OFF_GC1      7'h00
`define MFRD_OFF_GC2      7'h01
`define MFRD_OFF_SRC      7'h08
`define MFRD_OFF_PID      7'h09
`define MFRD_OFF_TMR0     7'h10
`define MFRD_OFF_TMR1     7'h11
`define MFRD_OFF_TMR2     7'h12
`define MFRD_OFF_TMR3     7'h13
`define MFRD_OFF_MODE     7'h20
`define MFRD_OFF_IEN      7'h21
`define MFRD_OFF_STAT     7'h42
`define MFRD_OFF_CNT_LO   7'h60
`define MFRD_OFF_CNT_HI   7'h61

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MFRD_GC1_SEC_MODE 0
`define MFRD_GC1_E3       1
`define MFRD_MODE_CH_EN   0
`define MFRD_ST_WRAP      0
`define MFRD_ST_ALARM     1

// ----------------------------------------------------------------
// Reset and load values
// ----------------------------------------------------------------
`define MFRD_RST_GC1      8'h00
`define MFRD_RST_GC2      8'h00
`define MFRD_RST_MODE     8'h00
`define MFRD_RST_IEN      8'h00
`define MFRD_RST_TMR      32'h0000_0000
`define MFRD_TMR_DS3      32'h02AA_9E00
`define MFRD_TMR_E3       32'h020C_6A00
// Identity byte: arbitrary value, it names no real part
`define MFRD_PART_ID      8'h5A

`endif

// File: logic/mfrd_event_ctr.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Event counter, cleared by read, flags roll-over
// ----------------------------------------------------------------
module mfrd_event_ctr (
  input wire core_clk_i,   // Core clock
  input wire rst_i,        // Sync reset, high
  input wire inc_i,        // Count one event
  input wire clr_i,        // Clear from processor read
  output wire [15:0] cnt_o, // Current count
  output reg wrap_o        // Pulse on roll-over to zero
);

  reg [15:0] cnt_q;
  reg [15:0] cnt_d;

  // An event coinciding with the clear counts as one, so none is lost
  always @*
  begin
    if (clr_i)
      cnt_d = {15'h0000, inc_i};
    else if (inc_i)
      cnt_d = cnt_q + 16'h0001;
    else
      cnt_d = cnt_q;
  end

  // Count register and roll-over pulse
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 16'h0000;
      wrap_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      wrap_o <= inc_i & ~clr_i & (cnt_q == 16'hFFFF);
    end
  end

  assign cnt_o = cnt_q;

endmodule // mfrd_event_ctr

// File: logic/mfrd_regbank.v
`timescale 1ns/100ps
`include "mfrd_defs.vh"

module mfrd_regbank (
  input wire core_clk_i,          // 20 MHz core clock
  input wire rst_i,               // Sync reset, high
  input wire cs_first_n_i,        // Select of first set, low
  input wire cs_second_n_i,       // Select of second set, low
  input wire rd_n_i,              // Read strobe, low
  input wire wr_n_i,              // Write strobe, low
  input wire [8:0] addr_i,        // Framer and offset
  input wire [7:0] data_i,        // Data bus input side
  output reg [7:0] data_o,        // Data bus output side
  output wire data_oe_o,          // Data bus drive enable
  input wire [7:0] event_i,       // Count event per channel
  input wire [7:0] alarm_i,       // Alarm event per channel
  output wire [7:0] chan_en_o,    // Channel enable bits
  output wire [1:0] sec_tick_o,   // Pulse per set each time its timer reaches zero
  output reg irq_out_n_first_o,   // Interrupt of set one, low
  output reg irq_out_n_second_o   // Interrupt of set two, low
);

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  wire sel_any;
  wire set_sel;
  wire rd_act;
  wire wr_act;
  wire rd_start;
  wire wr_start;
  wire [2:0] ch;
  wire [6:0] off;
  wire gen;
  reg rd_q;
  reg wr_q;

  // Exactly one select must be low; both low is ignored
  assign sel_any = ~cs_first_n_i ^ ~cs_second_n_i;
  assign set_sel = ~cs_second_n_i;
  assign rd_act = sel_any & ~rd_n_i & wr_n_i;
  assign wr_act = sel_any & ~wr_n_i & rd_n_i;
  assign data_oe_o = rd_act;

  // Framer number from the top bits, offset from the rest
  assign ch = {set_sel, addr_i[8:7]};
  assign off = addr_i[6:0];
  assign gen = (addr_i[8:7] == 2'b00);

  // Side effects act once, on the first cycle of each strobe
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end

  assign rd_start = rd_act & ~rd_q;
  assign wr_start = wr_act & ~wr_q;

  // ----------------------------------------------------------------
  // Per-channel registers
  // ----------------------------------------------------------------
  wire [63:0] mode_w;
  wire [63:0] ien_w;
  wire [63:0] stat_w;
  wire [127:0] cnt_w;
  wire [63:0] hi_w;
  wire [7:0] pend;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_ch
      reg [7:0] mode_q;
      reg [7:0] ien_q;
      reg [1:0] stat_q;
      reg [7:0] hi_q;
      wire hit;
      wire wrap;
      wire stat_clr;
      wire cnt_clr;
      wire [15:0] cnt;

      assign hit = (ch == g);
      assign stat_clr = rd_start & hit & (off == `MFRD_OFF_STAT);
      assign cnt_clr = rd_start & hit & (off == `MFRD_OFF_CNT_LO);

      // Counter only runs while the channel is enabled
      mfrd_event_ctr u_ctr (
        .core_clk_i (core_clk_i),
        .rst_i (rst_i),
        .inc_i (event_i[g] & mode_q[`MFRD_MODE_CH_EN]),
        .clr_i (cnt_clr),
        .cnt_o (cnt),
        .wrap_o (wrap)
      );

      // Control storage; disabling keeps every bit as written
      always @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          mode_q <= `MFRD_RST_MODE;
          ien_q <= `MFRD_RST_IEN;
        end
        else if (wr_start & hit & (off == `MFRD_OFF_MODE))
          mode_q <= data_i;
        else if (wr_start & hit & (off == `MFRD_OFF_IEN))
          ien_q <= data_i;
      end

      // Sticky status: a new event beats a same-cycle read clear
      always @(posedge core_clk_i)
      begin
        if (rst_i)
          stat_q <= 2'b00;
        else
        begin
          stat_q[`MFRD_ST_WRAP] <= wrap |
            (stat_q[`MFRD_ST_WRAP] & ~stat_clr);
          stat_q[`MFRD_ST_ALARM] <= alarm_i[g] |
            (stat_q[`MFRD_ST_ALARM] & ~stat_clr);
        end
      end

      // High byte frozen by the low-byte read that clears the count
      always @(posedge core_clk_i)
      begin
        if (rst_i)
          hi_q <= 8'h00;
        else if (cnt_clr)
          hi_q <= cnt[15:8];
      end

      assign pend[g] = |(stat_q & ien_q[1:0]);
      assign mode_w[8*g +: 8] = mode_q;
      assign ien_w[8*g +: 8] = ien_q;
      assign stat_w[8*g +: 8] = {6'b00_0000, stat_q};
      assign cnt_w[16*g +: 16] = cnt;
      assign hi_w[8*g +: 8] = hi_q;
      assign chan_en_o[g] = mode_q[`MFRD_MODE_CH_EN];
    end
  endgenerate

  // ----------------------------------------------------------------
  // General registers, one copy per select
  // ----------------------------------------------------------------
  wire [15:0] gc1_w;
  wire [15:0] gc2_w;
  wire [63:0] tmr_w;

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1)
    begin : g_set
      reg [7:0] gc1_q;
      reg [7:0] gc2_q;
      reg [31:0] tmr_q;
      reg sec_on_q;
      reg tick_q;
      wire ghit;
      wire sec_on;
      wire [31:0] load;

      // Only framer one of each select holds these
      assign ghit = wr_start & (set_sel == s) & gen;
      assign sec_on = gc1_q[`MFRD_GC1_SEC_MODE];
      assign load = gc1_q[`MFRD_GC1_E3] ? `MFRD_TMR_E3
                                        : `MFRD_TMR_DS3;

      // General control bytes
      always @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          gc1_q <= `MFRD_RST_GC1;
          gc2_q <= `MFRD_RST_GC2;
        end
        else if (ghit & (off == `MFRD_OFF_GC1))
          gc1_q <= data_i;
        else if (ghit & (off == `MFRD_OFF_GC2))
          gc2_q <= data_i;
      end

      // Down-counting timer; a byte write overrides the count,
      // which lets software trim the period while it runs
      always @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          tmr_q <= `MFRD_RST_TMR;
          sec_on_q <= 1'b0;
          tick_q <= 1'b0;
        end
        else
        begin
          sec_on_q <= sec_on;
          tick_q <= 1'b0;
          if (ghit & (off == `MFRD_OFF_TMR0))
            tmr_q[7:0] <= data_i;
          else if (ghit & (off == `MFRD_OFF_TMR1))
            tmr_q[15:8] <= data_i;
          else if (ghit & (off == `MFRD_OFF_TMR2))
            tmr_q[23:16] <= data_i;
          else if (ghit & (off == `MFRD_OFF_TMR3))
            tmr_q[31:24] <= data_i;
          else if (sec_on & ~sec_on_q)
            tmr_q <= load;
          else if (sec_on & (tmr_q == 32'h0000_0000))
          begin
            tmr_q <= load;
            tick_q <= 1'b1;
          end
          else if (sec_on)
            tmr_q <= tmr_q - 32'h0000_0001;
        end
      end

      assign gc1_w[8*s +: 8] = gc1_q;
      assign gc2_w[8*s +: 8] = gc2_q;
      assign tmr_w[32*s +: 32] = tmr_q;
      assign sec_tick_o[s] = tick_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  reg [7:0] rdata_d;
  wire [5:0] b8;
  wire [6:0] b16;
  wire [5:0] b32;

  assign b8 = {ch, 3'b000};
  assign b16 = {ch, 4'b0000};
  assign b32 = {set_sel, 5'b0_0000};

  // Unlisted offsets and general offsets off framer one read zero
  always @*
  begin
    rdata_d = 8'h00;
    if (gen & (off == `MFRD_OFF_GC1))
      rdata_d = gc1_w[8*set_sel +: 8];
    else if (gen & (off == `MFRD_OFF_GC2))
      rdata_d = gc2_w[8*set_sel +: 8];
    else if (gen & (off == `MFRD_OFF_SRC))
      rdata_d = {4'h0, pend[4*set_sel +: 4]};
    else if (gen & (off == `MFRD_OFF_PID))
      rdata_d = `MFRD_PART_ID;
    else if (gen & (off == `MFRD_OFF_TMR0))
      rdata_d = tmr_w[b32 +: 8];
    else if (gen & (off == `MFRD_OFF_TMR1))
      rdata_d = tmr_w[b32 + 6'd8 +: 8];
    else if (gen & (off == `MFRD_OFF_TMR2))
      rdata_d = tmr_w[b32 + 6'd16 +: 8];
    else if (gen & (off == `MFRD_OFF_TMR3))
      rdata_d = tmr_w[b32 + 6'd24 +: 8];
    else if (off == `MFRD_OFF_MODE)
      rdata_d = mode_w[b8 +: 8];
    else if (off == `MFRD_OFF_IEN)
      rdata_d = ien_w[b8 +: 8];
    else if (off == `MFRD_OFF_STAT)
      rdata_d = stat_w[b8 +: 8];
    else if (off == `MFRD_OFF_CNT_LO)
      rdata_d = cnt_w[b16 +: 8];
    else if (off == `MFRD_OFF_CNT_HI)
      rdata_d = hi_w[b8 +: 8];
  end

  // Data captured at strobe start so the clear cannot corrupt it
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      data_o <= 8'h00;
    else if (rd_start)
      data_o <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Interrupt pins, one per select
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      irq_out_n_first_o <= 1'b1;
      irq_out_n_second_o <= 1'b1;
    end
    else
    begin
      irq_out_n_first_o <= ~|pend[3:0];
      irq_out_n_second_o <= ~|pend[7:4];
    end
  end

endmodule // mfrd_regbank

// File: sim/mfrd_regbank_chk.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Checker of bus answers, enables, ticks and interrupt pins
// ----------------------------------------------------------------
module mfrd_regbank_chk (
  input wire logic core_clk_i,          // Core clock
  input wire logic rst_i,               // Sync reset
  input wire logic cs_first_n_i,        // Set one select
  input wire logic cs_second_n_i,       // Set two select
  input wire logic rd_n_i,              // Read strobe
  input wire logic wr_n_i,              // Write strobe
  input wire logic [8:0] addr_i,        // Address
  input wire logic [7:0] data_i,        // Write data
  input wire logic [7:0] data_o,        // Read data
  input wire logic data_oe_o,           // Drive enable
  input wire logic [7:0] event_i,       // Count events
  input wire logic [7:0] alarm_i,       // Alarm events
  input wire logic [7:0] chan_en_o,     // Channel enables
  input wire logic [1:0] sec_tick_o,    // Second ticks
  input wire logic irq_out_n_first_o,   // Interrupt one
  input wire logic irq_out_n_second_o   // Interrupt two
);
  reg [3:0] cause_q;
  reg [3:0] acc_q;

  // Recent history, loose on purpose: exact lag differs per source
  always @(posedge core_clk_i)
  begin
    cause_q <= {cause_q[2:0], (|alarm_i) | (|event_i) | ~wr_n_i};
    acc_q <= {acc_q[2:0], ~rd_n_i | ~wr_n_i};
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_take;
    !wr_n_i && $past(wr_n_i) && rd_n_i;
  endsequence

  a_oe_read_only: assert property (data_oe_o |->
    !rd_n_i && wr_n_i && (cs_first_n_i ^ cs_second_n_i))
    else $error("data bus driven outside a read");
  a_oe_on_read: assert property (
    !rd_n_i && wr_n_i && !cs_first_n_i && cs_second_n_i |-> data_oe_o)
    else $error("read without drive enable");
  a_reset_quiet: assert property ($fell(rst_i) |->
    irq_out_n_first_o && irq_out_n_second_o && chan_en_o == 8'h00)
    else $error("outputs not quiet after reset");
  a_en_first: assert property (s_wr_take ##0 (!cs_first_n_i
    && cs_second_n_i && addr_i == 9'h020) |=> chan_en_o[0] == $past(data_i[0]))
    else $error("channel one enable not written");
  a_en_second: assert property (s_wr_take ##0 (cs_first_n_i
    && !cs_second_n_i && addr_i == 9'h1A0) |=> chan_en_o[7] == $past(data_i[0]))
    else $error("channel eight enable not written");
  a_en_hold: assert property ($changed(chan_en_o) |->
    $past(!wr_n_i) && $past(wr_n_i, 2))
    else $error("enable changed without a write");
  a_data_hold: assert property ($changed(data_o) |-> $past(!rd_n_i)
    && ($past(rd_n_i, 2) || $past(rd_n_i, 3)))
    else $error("read data changed without a read");
  a_tick_pulse: assert property (sec_tick_o[0] |=> !sec_tick_o[0])
    else $error("second tick longer than one cycle");
  a_tick_pulse_two: assert property (sec_tick_o[1] |=> !sec_tick_o[1])
    else $error("set two tick longer than one cycle");
  a_irq_cause: assert property ($fell(irq_out_n_first_o)
    || $fell(irq_out_n_second_o) |-> |cause_q)
    else $error("interrupt without a cause");
  a_irq_release: assert property ($rose(irq_out_n_first_o)
    || $rose(irq_out_n_second_o) |-> |acc_q)
    else $error("interrupt released without access");
endmodule // mfrd_regbank_chk

bind mfrd_regbank mfrd_regbank_chk u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_first_n_i(cs_first_n_i),
  .cs_second_n_i(cs_second_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
  .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .event_i(event_i), .alarm_i(alarm_i),
  .chan_en_o(chan_en_o), .sec_tick_o(sec_tick_o),
  .irq_out_n_first_o(irq_out_n_first_o),
  .irq_out_n_second_o(irq_out_n_second_o));

// File: sim/mfrd_cpu_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Processor model: one access at a time, idle edge between
// ----------------------------------------------------------------
module mfrd_cpu_model (
  input wire logic core_clk_i,       // Core clock
  input wire logic [7:0] rdata_i,    // Read data
  output logic cs_first_n_o,         // Set one select
  output logic cs_second_n_o,        // Set two select
  output logic rd_n_o,               // Read strobe
  output logic wr_n_o,               // Write strobe
  output logic [8:0] addr_o,         // Address
  output logic [7:0] wdata_o         // Write data
);
  initial
  begin
    {cs_first_n_o, cs_second_n_o, rd_n_o, wr_n_o} = 4'hF;
    addr_o = 9'h000;
    wdata_o = 8'h00;
  end

  // Select, address, data and strobe move together after an edge
  task start(input logic sel, input logic [8:0] a, input logic [7:0] d,
    input logic rd);
  begin
    @(posedge core_clk_i);
    cs_first_n_o <= sel;
    cs_second_n_o <= ~sel;
    addr_o <= a;
    wdata_o <= d;
    rd_n_o <= ~rd;
    wr_n_o <= rd;
  end
  endtask

  // Released bus shows inverted values, never the last ones
  task stop;
  begin
    {cs_first_n_o, cs_second_n_o, rd_n_o, wr_n_o} <= 4'hF;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  end
  endtask

  // Static bits are also written with channels enabled
  task wr(input logic sel, input logic [8:0] a, input logic [7:0] d);
  begin
    start(sel, a, d, 1'b0);
    @(posedge core_clk_i);
    stop;
  end
  endtask

  task rd(input logic sel, input logic [8:0] a, output logic [7:0] d);
  begin
    start(sel, a, 8'h3C, 1'b1);
    repeat (2) @(posedge core_clk_i);
    #1 d = rdata_i;
    @(posedge core_clk_i);
    stop;
  end
  endtask
endmodule // mfrd_cpu_model

// File: sim/test_mfrd_regbank.sv
`timescale 1ns/100ps
`include "mfrd_defs.vh"
module test_mfrd_regbank;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] event_i = 8'h00;
  logic [7:0] alarm_i = 8'h00;
  wire cs_a_n, cs_b_n, rd_n, wr_n, data_oe, irq_a, irq_b;
  wire [8:0] addr;
  wire [7:0] wdata, rdata, chan_en;
  wire [1:0] tick;
  integer error_cnt = 0;
  integer checked = 0;
  integer cycles = 0;
  integer i;
  logic tick_seen = 1'b0;
  logic tick_two_seen = 1'b0;
  logic [7:0] rv;
  logic [55:0] rsv = {7'h02, 7'h07, 7'h14, 7'h36, 7'h53, 7'h71, 7'h7F, 7'h0A};

  always #25 core_clk_i = ~core_clk_i;

  mfrd_regbank uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cs_first_n_i(cs_a_n), .cs_second_n_i(cs_b_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(rdata),
    .data_oe_o(data_oe), .event_i(event_i), .alarm_i(alarm_i),
    .chan_en_o(chan_en), .sec_tick_o(tick), .irq_out_n_first_o(irq_a),
    .irq_out_n_second_o(irq_b));
  mfrd_cpu_model cpu (.core_clk_i(core_clk_i), .rdata_i(rdata),
    .cs_first_n_o(cs_a_n), .cs_second_n_o(cs_b_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));

  // Hang guard, sized for one full counter roll-over plus margin
  always @(posedge core_clk_i)
  begin
    cycles = cycles + 1;
    if (tick[0] === 1'b1)
      tick_seen = 1'b1;
    if (tick[1] === 1'b1)
      tick_two_seen = 1'b1;
    if (cycles == 90000)
    begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end

  task finish_test;
  begin
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  end
  endtask

  task rchk(input logic s, input logic [8:0] a, input logic [7:0] exp);
  begin
    cpu.rd(s, a, rv);
    cmp($sformatf("reg %0d:%h", s, a), exp, rv);
  end
  endtask

  task t_general;
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      rchk(i[0], 9'h000, 8'h00);
      rchk(i[0], 9'h009, `MFRD_PART_ID);
      rchk(i[0], 9'h021, 8'h00);
    end
    cpu.wr(1'b0, 9'h001, 8'hA5);
    rchk(1'b0, 9'h001, 8'hA5);
    rchk(1'b1, 9'h001, 8'h00);
    cpu.wr(1'b0, 9'h101, 8'hFF);
    rchk(1'b0, 9'h101, 8'h00);
    rchk(1'b0, 9'h001, 8'hA5);
  end
  endtask

  task t_reserved;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      cpu.wr(1'b0, {2'b00, rsv[i*7+:7]}, 8'hFF);
      rchk(1'b0, {2'b00, rsv[i*7+:7]}, 8'h00);
    end
    cpu.wr(1'b0, 9'h009, 8'hFF);
    rchk(1'b0, 9'h009, `MFRD_PART_ID);
  end
  endtask

  task t_channels;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      cpu.wr(i[2], {i[1:0], 7'h20}, 8'h01);
      #1 cmp("chan_en", 8'h01 << i, chan_en);
      cpu.wr(i[2], {i[1:0], 7'h20}, 8'h00);
    end
    cpu.wr(1'b1, 9'h0A0, 8'h01);
    cpu.wr(1'b1, 9'h0A1, 8'h03);
    cpu.wr(1'b1, 9'h0A0, 8'h00);
    rchk(1'b1, 9'h0A1, 8'h03);
  end
  endtask

  task t_counter;
  begin
    cpu.wr(1'b0, 9'h020, 8'h01);
    cpu.wr(1'b0, 9'h0A0, 8'h01);
    cpu.wr(1'b0, 9'h021, 8'h01);
    @(posedge core_clk_i) event_i <= 8'h03;
    repeat (3) @(posedge core_clk_i);
    event_i <= 8'h00;
    rchk(1'b0, 9'h060, 8'h03);
    rchk(1'b0, 9'h061, 8'h00);
    rchk(1'b0, 9'h060, 8'h00);
    rchk(1'b0, 9'h0E0, 8'h03);
    // 300 events carry into the high byte, frozen by the low read
    @(posedge core_clk_i) event_i <= 8'h02;
    repeat (300) @(posedge core_clk_i);
    event_i <= 8'h00;
    rchk(1'b0, 9'h0E0, 8'h2C);
    rchk(1'b0, 9'h0E1, 8'h01);
    @(posedge core_clk_i) event_i <= 8'h01;
    repeat (65536) @(posedge core_clk_i);
    event_i <= 8'h00;
    repeat (4) @(posedge core_clk_i);
    #1 cmp("irq_a", 8'h00, {7'h00, irq_a});
    rchk(1'b0, 9'h008, 8'h01);
    rchk(1'b0, 9'h042, 8'h01);
    #1 cmp("irq_a", 8'h01, {7'h00, irq_a});
    rchk(1'b0, 9'h060, 8'h00);
    cpu.wr(1'b0, 9'h020, 8'h00);
    cpu.wr(1'b0, 9'h0A0, 8'h00);
  end
  endtask

  task alarm_once;
  begin
    @(posedge core_clk_i) alarm_i <= 8'h10;
    @(posedge core_clk_i) alarm_i <= 8'h00;
    repeat (2) @(posedge core_clk_i);
  end
  endtask

  task t_alarm;
  begin
    cpu.wr(1'b1, 9'h020, 8'h01);
    alarm_once;
    #1 cmp("irq_b masked", 8'h01, {7'h00, irq_b});
    rchk(1'b1, 9'h042, 8'h02);
    cpu.wr(1'b1, 9'h021, 8'h02);
    alarm_once;
    #1 cmp("irq_b", 8'h00, {7'h00, irq_b});
    cmp("irq_a", 8'h01, {7'h00, irq_a});
    rchk(1'b1, 9'h008, 8'h01);
    rchk(1'b0, 9'h008, 8'h00);
    rchk(1'b1, 9'h042, 8'h02);
    #1 cmp("irq_b", 8'h01, {7'h00, irq_b});
    cpu.wr(1'b1, 9'h020, 8'h00);
  end
  endtask

  task t_timer;
  begin
    cpu.wr(1'b0, 9'h000, 8'h01);
    rchk(1'b0, 9'h013, 8'h02);
    rchk(1'b0, 9'h012, 8'hAA);
    cpu.wr(1'b0, 9'h000, 8'h00);
    cpu.wr(1'b0, 9'h000, 8'h03);
    rchk(1'b0, 9'h013, 8'h02);
    rchk(1'b0, 9'h012, 8'h0C);
    for (i = 3; i >= 0; i = i - 1)
      cpu.wr(1'b0, 9'h010 + i[8:0], (i == 0) ? 8'h05 : 8'h00);
    repeat (20) @(posedge core_clk_i);
    cmp("tick", 8'h01, {7'h00, tick_seen});
    cpu.wr(1'b0, 9'h000, 8'h00);
    // Second set has its own timer and its own tick
    cpu.wr(1'b1, 9'h000, 8'h01);
    rchk(1'b1, 9'h013, 8'h02);
    for (i = 3; i >= 0; i = i - 1)
      cpu.wr(1'b1, 9'h010 + i[8:0], (i == 0) ? 8'h05 : 8'h00);
    repeat (20) @(posedge core_clk_i);
    cmp("tick two", 8'h01, {7'h00, tick_two_seen});
    cpu.wr(1'b1, 9'h000, 8'h00);
  end
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_general;
    t_reserved;
    t_channels;
    t_counter;
    t_alarm;
    t_timer;
    finish_test;
  end
endmodule // test_mfrd_regbank
